// File: verilog/cfgfd_decode.sv
module cfgfd_decode
(
    // clock and reset
    input  wire logic                     clock_i,
    input  wire logic                     rstn_i,
    // table access port
    input  wire logic [21:0]              tbl_addr_i,
    input  wire logic                     tbl_rd_i,
    input  wire logic                     tbl_wr_i,
    input  wire logic [7:0]               tbl_wdata_i,
    input  wire logic                     prog_mode_i,
    output logic      [7:0]               tbl_rdata_o,
    // live controls from other units
    input  wire logic                     soft_brownout_on_i,
    input  wire logic                     watchdog_soft_on_i,
    input  wire logic                     sleep_i,
    // decoded configuration
    output cfgfd_pkg::cfgfd_out_type      cfg_o
);
    cfgfd_pkg::cfgfd_state_type s_ff;
    cfgfd_pkg::cfgfd_state_type nxt_s;

    // ------------------------------------------------------------
    // clear-only merge for protection bytes
    // ------------------------------------------------------------
    function automatic logic [7:0] clr_only(input logic [7:0] cur,
                                            input logic [7:0] wd,
                                            input logic [7:0] msk);
        clr_only = (cur & wd & msk) | (cur & ~msk);
    endfunction

    always_comb
    begin
        nxt_s = s_ff;
        // reset outside program mode models blank cells at power-on
        if (!rstn_i && !prog_mode_i)
        begin
            nxt_s.pwr_bor  = cfgfd_pkg::RST_PWR_BOR;
            nxt_s.wdog     = cfgfd_pkg::RST_WDOG;
            nxt_s.pin_tmr  = cfgfd_pkg::RST_PIN_TMR;
            nxt_s.dbg_core = cfgfd_pkg::RST_DBG_CORE;
            nxt_s.blk_cp   = cfgfd_pkg::RST_BLK;
            nxt_s.boot_cp  = cfgfd_pkg::RST_BOOT_CP;
            nxt_s.blk_wp   = cfgfd_pkg::RST_BLK;
        end
        // table writes, byte at a time; programmable only in program mode
        if (tbl_wr_i && prog_mode_i)
        begin
            if (tbl_addr_i == cfgfd_pkg::ADDR_PWR_BOR)
                nxt_s.pwr_bor = tbl_wdata_i & cfgfd_pkg::MASK_PWR_BOR;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_WDOG)
                nxt_s.wdog = tbl_wdata_i & cfgfd_pkg::MASK_WDOG;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_PIN_TMR)
                nxt_s.pin_tmr = tbl_wdata_i & cfgfd_pkg::MASK_PIN_TMR;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_DBG_CORE)
                nxt_s.dbg_core = tbl_wdata_i & cfgfd_pkg::MASK_DBG_CORE;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BLK_CP)
                nxt_s.blk_cp = clr_only(s_ff.blk_cp, tbl_wdata_i, cfgfd_pkg::MASK_BLK);
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BOOT_CP)
                nxt_s.boot_cp = clr_only(s_ff.boot_cp, tbl_wdata_i, cfgfd_pkg::MASK_BOOT_CP);
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BLK_WP)
                nxt_s.blk_wp = clr_only(s_ff.blk_wp, tbl_wdata_i, cfgfd_pkg::MASK_BLK);
        end
        // read mux, unmapped reads zero
        nxt_s.rdata = 8'h00;
        if (tbl_rd_i)
        begin
            if (tbl_addr_i == cfgfd_pkg::ADDR_PWR_BOR)
                nxt_s.rdata = s_ff.pwr_bor;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_WDOG)
                nxt_s.rdata = s_ff.wdog;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_PIN_TMR)
                nxt_s.rdata = s_ff.pin_tmr;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_DBG_CORE)
                nxt_s.rdata = s_ff.dbg_core;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BLK_CP)
                nxt_s.rdata = s_ff.blk_cp;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BOOT_CP)
                nxt_s.rdata = s_ff.boot_cp;
            else if (tbl_addr_i == cfgfd_pkg::ADDR_BLK_WP)
                nxt_s.rdata = s_ff.blk_wp;
        end
        // ------------------------------------------------------------
        // decode: latched only while reset is held
        // ------------------------------------------------------------
        if (!rstn_i)
        begin
            nxt_s.dec.usb_regulator_on = s_ff.pwr_bor[cfgfd_pkg::POS_VREG];
            nxt_s.dec.brownout_level_sel = s_ff.pwr_bor[cfgfd_pkg::POS_BORV +: 2];
            nxt_s.dec.brownout_mode =
                cfgfd_pkg::cfgfd_bor_type'(s_ff.pwr_bor[cfgfd_pkg::POS_BORE +: 2]);
            nxt_s.dec.powerup_delay_timer = ~s_ff.pwr_bor[cfgfd_pkg::POS_PUDLY];
            nxt_s.dec.watchdog_ratio =
                16'h0001 << s_ff.wdog[cfgfd_pkg::POS_WDPS +: 4];
            nxt_s.dec.watchdog_hard_on = s_ff.wdog[cfgfd_pkg::POS_WDEN];
            nxt_s.dec.external_reset_pin = s_ff.pin_tmr[cfgfd_pkg::POS_RSTPIN];
            nxt_s.dec.port_e_bit3_input = ~s_ff.pin_tmr[cfgfd_pkg::POS_RSTPIN];
            nxt_s.dec.lowpower_t1_osc = s_ff.pin_tmr[cfgfd_pkg::POS_LPT1];
            nxt_s.dec.analog_pin_control = s_ff.pin_tmr[cfgfd_pkg::POS_PBAD]
                ? cfgfd_pkg::ANALOG_ON_RESET : cfgfd_pkg::DIGITAL_ON_RESET;
            nxt_s.dec.capcmp2_route = s_ff.pin_tmr[cfgfd_pkg::POS_CAPROUTE];
            nxt_s.dec.debug_pins_dedicated = ~s_ff.dbg_core[cfgfd_pkg::POS_DBG];
            nxt_s.dec.extended_isa_on = s_ff.dbg_core[cfgfd_pkg::POS_XIN];
            nxt_s.dec.debug_port_on = s_ff.dbg_core[cfgfd_pkg::POS_ICP];
            nxt_s.dec.low_voltage_prog_on = s_ff.dbg_core[cfgfd_pkg::POS_LOWV];
            nxt_s.dec.stack_fault_reset_on = s_ff.dbg_core[cfgfd_pkg::POS_STV];
            nxt_s.dec.code_lock_block = ~s_ff.blk_cp[3:0];
            nxt_s.dec.code_lock_eeprom = ~s_ff.boot_cp[cfgfd_pkg::POS_EELOCK];
            nxt_s.dec.code_lock_boot = ~s_ff.boot_cp[cfgfd_pkg::POS_BOOTLOCK];
            nxt_s.dec.write_lock_block = ~s_ff.blk_wp[3:0];
        end
        // live enables combine latched mode with runtime control bits
        case (nxt_s.dec.brownout_mode)
            cfgfd_pkg::BOR_HW:         nxt_s.dec.brownout_active = 1'b1;
            cfgfd_pkg::BOR_HW_NOSLEEP: nxt_s.dec.brownout_active = ~sleep_i;
            cfgfd_pkg::BOR_SOFT:       nxt_s.dec.brownout_active = soft_brownout_on_i;
            default:                   nxt_s.dec.brownout_active = 1'b0;
        endcase
        // soft enable only matters when the latched hard bit is clear
        nxt_s.dec.watchdog_run = nxt_s.dec.watchdog_hard_on | watchdog_soft_on_i;
    end

    always_ff @(posedge clock_i)
    begin
        s_ff <= nxt_s;
    end

    assign tbl_rdata_o = s_ff.rdata;
    assign cfg_o       = s_ff.dec;

    // ------------------------------------------------------------
    // decode checks: latched fields at the first edge after reset, reset pin pair and live enables every cycle
    // ------------------------------------------------------------
    AST_REGULATOR: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.usb_regulator_on == $past(s_ff.pwr_bor[cfgfd_pkg::POS_VREG])
    )
    else $error("regulator enable differs from its config bit");

    AST_BOR_MODE: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.brownout_mode == $past(s_ff.pwr_bor[cfgfd_pkg::POS_BORE +: 2])
    )
    else $error("brownout mode differs from its config field");

    AST_BOR_HW: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.brownout_mode == cfgfd_pkg::BOR_HW
        |=> cfg_o.brownout_active
    )
    else $error("hardware brownout not active");

    AST_BOR_NOSLEEP: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.brownout_mode == cfgfd_pkg::BOR_HW_NOSLEEP
        |=> cfg_o.brownout_active == !$past(sleep_i)
    )
    else $error("brownout not off in sleep");

    AST_BOR_SOFT: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.brownout_mode == cfgfd_pkg::BOR_SOFT
        |=> cfg_o.brownout_active == $past(soft_brownout_on_i)
    )
    else $error("soft brownout does not follow its control");

    AST_BOR_OFF: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.brownout_mode == cfgfd_pkg::BOR_OFF
        |=> !cfg_o.brownout_active
    )
    else $error("disabled brownout is active");

    AST_BOR_LEVEL: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.brownout_level_sel == $past(s_ff.pwr_bor[cfgfd_pkg::POS_BORV +: 2])
    )
    else $error("brownout level differs from its config field");

    AST_POWERUP: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.powerup_delay_timer == !$past(s_ff.pwr_bor[cfgfd_pkg::POS_PUDLY])
    )
    else $error("powerup delay not active low");

    AST_INDEPENDENT: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i) && ($past(s_ff.pwr_bor[cfgfd_pkg::POS_BORE +: 2]) == 2'b00)
        |-> cfg_o.powerup_delay_timer == !$past(s_ff.pwr_bor[cfgfd_pkg::POS_PUDLY])
    )
    else $error("powerup delay tied to brownout");

    AST_WDOG_RATIO: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.watchdog_ratio == (16'h0001 << $past(s_ff.wdog[cfgfd_pkg::POS_WDPS +: 4]))
    )
    else $error("watchdog ratio not a power of two of code");

    AST_WDOG_HARD: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.watchdog_hard_on
        |=> cfg_o.watchdog_run
    )
    else $error("hard watchdog not running");

    AST_WDOG_SOFT: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        !cfg_o.watchdog_hard_on
        |=> cfg_o.watchdog_run == $past(watchdog_soft_on_i)
    )
    else $error("soft watchdog does not follow its control");

    AST_RESET_PIN: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.external_reset_pin != cfg_o.port_e_bit3_input
    )
    else $error("reset pin and input pin both on or both off");

    AST_T1_OSC: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.lowpower_t1_osc == $past(s_ff.pin_tmr[cfgfd_pkg::POS_LPT1])
    )
    else $error("timer one oscillator mode wrong");

    AST_ANALOG: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.analog_pin_control == ($past(s_ff.pin_tmr[cfgfd_pkg::POS_PBAD])
            ? cfgfd_pkg::ANALOG_ON_RESET : cfgfd_pkg::DIGITAL_ON_RESET)
    )
    else $error("analog control reset state wrong");

    AST_CAP_ROUTE: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.capcmp2_route == $past(s_ff.pin_tmr[cfgfd_pkg::POS_CAPROUTE])
    )
    else $error("capture compare routing wrong");

    AST_DEBUG_PINS: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.debug_pins_dedicated == !$past(s_ff.dbg_core[cfgfd_pkg::POS_DBG])
    )
    else $error("debug pin dedication wrong");

    AST_EXT_ISA: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.extended_isa_on == $past(s_ff.dbg_core[cfgfd_pkg::POS_XIN])
    )
    else $error("extended instruction enable wrong");

    AST_DEBUG_PORT: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.debug_port_on == $past(s_ff.dbg_core[cfgfd_pkg::POS_ICP])
    )
    else $error("debug port enable wrong");

    AST_LOW_VOLT: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.low_voltage_prog_on == $past(s_ff.dbg_core[cfgfd_pkg::POS_LOWV])
    )
    else $error("low voltage programming enable wrong");

    AST_STACK_RESET: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.stack_fault_reset_on == $past(s_ff.dbg_core[cfgfd_pkg::POS_STV])
    )
    else $error("stack fault reset enable wrong");

    // ------------------------------------------------------------
    // per-block protection checks, then eeprom and boot lock checks
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_block_lock
            AST_CODE_LOCK: assert property (
                @(posedge clock_i) disable iff (!rstn_i)
                $rose(rstn_i)
                |-> cfg_o.code_lock_block[g] == !$past(s_ff.blk_cp[g])
            )
            else $error("block code lock not active low");

            AST_WRITE_LOCK: assert property (
                @(posedge clock_i) disable iff (!rstn_i)
                $rose(rstn_i)
                |-> cfg_o.write_lock_block[g] == !$past(s_ff.blk_wp[g])
            )
            else $error("block write lock not active low");
        end
    endgenerate

    AST_EEPROM_LOCK: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.code_lock_eeprom == !$past(s_ff.boot_cp[cfgfd_pkg::POS_EELOCK])
    )
    else $error("eeprom code lock not active low");

    AST_BOOT_LOCK: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $rose(rstn_i)
        |-> cfg_o.code_lock_boot == !$past(s_ff.boot_cp[cfgfd_pkg::POS_BOOTLOCK])
    )
    else $error("boot code lock not active low");

    // ------------------------------------------------------------
    // storage and access checks
    // ------------------------------------------------------------
    AST_CLEAR_ONLY: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $past(rstn_i)
        |-> ({s_ff.blk_cp, s_ff.boot_cp, s_ff.blk_wp}
            & ~$past({s_ff.blk_cp, s_ff.boot_cp, s_ff.blk_wp})) == 24'h000000
    )
    else $error("protection bit went from zero to one");

    AST_UNIMPL_ZERO: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        ((s_ff.pwr_bor & ~cfgfd_pkg::MASK_PWR_BOR) == 8'h00)
        && ((s_ff.wdog & ~cfgfd_pkg::MASK_WDOG) == 8'h00)
        && ((s_ff.pin_tmr & ~cfgfd_pkg::MASK_PIN_TMR) == 8'h00)
        && ((s_ff.dbg_core & ~cfgfd_pkg::MASK_DBG_CORE) == 8'h00)
        && ((s_ff.blk_cp & ~cfgfd_pkg::MASK_BLK) == 8'h00)
        && ((s_ff.boot_cp & ~cfgfd_pkg::MASK_BOOT_CP) == 8'h00)
        && ((s_ff.blk_wp & ~cfgfd_pkg::MASK_BLK) == 8'h00)
    )
    else $error("unimplemented config bit holds a one");

    AST_UNMAPPED_READ: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        tbl_rd_i && (tbl_addr_i == cfgfd_pkg::ADDR_PIN_TMR - 22'h000001)
        |=> tbl_rdata_o == 8'h00
    )
    else $error("unmapped config byte reads nonzero");

    AST_HOLD: assert property (
        @(posedge clock_i) disable iff (!rstn_i)
        $past(rstn_i)
        |-> $stable({cfg_o.usb_regulator_on, cfg_o.brownout_level_sel,
            cfg_o.brownout_mode, cfg_o.powerup_delay_timer, cfg_o.watchdog_ratio,
            cfg_o.watchdog_hard_on, cfg_o.analog_pin_control, cfg_o.code_lock_block,
            cfg_o.write_lock_block, cfg_o.code_lock_eeprom, cfg_o.code_lock_boot})
    )
    else $error("decoded config changed outside reset");

    // ------------------------------------------------------------
    // scenario covers
    // ------------------------------------------------------------
    COV_PROG_WRITE: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        tbl_wr_i && prog_mode_i
    );

    COV_LOCK_CLEARED: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        s_ff.blk_cp != cfgfd_pkg::RST_BLK
    );

    COV_READ_BACK: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        tbl_rd_i ##1 tbl_rdata_o != 8'h00
    );

    COV_HARD_WATCHDOG: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        cfg_o.watchdog_hard_on && cfg_o.watchdog_run
    );
endmodule

// File: verilog/cfgfd_pkg.sv
package cfgfd_pkg;
    // ------------------------------------------------------------
    // byte addresses
    // ------------------------------------------------------------
    localparam logic [21:0] ADDR_PWR_BOR  = 22'h300002;
    localparam logic [21:0] ADDR_WDOG     = 22'h300003;
    localparam logic [21:0] ADDR_PIN_TMR  = 22'h300005;
    localparam logic [21:0] ADDR_DBG_CORE = 22'h300006;
    localparam logic [21:0] ADDR_BLK_CP   = 22'h300008;
    localparam logic [21:0] ADDR_BOOT_CP  = 22'h300009;
    localparam logic [21:0] ADDR_BLK_WP   = 22'h30000a;
    // ------------------------------------------------------------
    // implemented bit masks and unprogrammed values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_PWR_BOR  = 8'h3f;
    localparam logic [7:0] MASK_WDOG     = 8'h1f;
    localparam logic [7:0] MASK_PIN_TMR  = 8'h87;
    localparam logic [7:0] MASK_DBG_CORE = 8'he5;
    localparam logic [7:0] MASK_BLK      = 8'h0f;
    localparam logic [7:0] MASK_BOOT_CP  = 8'hc0;
    localparam logic [7:0] RST_PWR_BOR   = 8'h1f;
    localparam logic [7:0] RST_WDOG      = 8'h1f;
    localparam logic [7:0] RST_PIN_TMR   = 8'h83;
    localparam logic [7:0] RST_DBG_CORE  = 8'h85;
    localparam logic [7:0] RST_BLK       = 8'h0f;
    localparam logic [7:0] RST_BOOT_CP   = 8'hc0;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_VREG = 5;
    localparam int POS_BORV = 3;
    localparam int POS_BORE = 1;
    localparam int POS_PUDLY = 0;
    localparam int POS_WDPS = 1;
    localparam int POS_WDEN = 0;
    localparam int POS_RSTPIN = 7;
    localparam int POS_LPT1 = 2;
    localparam int POS_PBAD = 1;
    localparam int POS_CAPROUTE = 0;
    localparam int POS_DBG  = 7;
    localparam int POS_XIN  = 6;
    localparam int POS_ICP  = 5;
    localparam int POS_LOWV = 2;
    localparam int POS_STV  = 0;
    localparam int POS_EELOCK   = 7;
    localparam int POS_BOOTLOCK = 6;
    localparam logic [7:0] ANALOG_ON_RESET  = 8'h00;
    localparam logic [7:0] DIGITAL_ON_RESET = 8'h0f;

    typedef enum logic [1:0] {BOR_OFF, BOR_SOFT, BOR_HW_NOSLEEP, BOR_HW} cfgfd_bor_type;

    typedef struct packed {
        logic       usb_regulator_on;
        logic [1:0] brownout_level_sel;
        cfgfd_bor_type brownout_mode;
        logic       brownout_active;
        logic       powerup_delay_timer;
        logic [15:0] watchdog_ratio;
        logic       watchdog_hard_on;
        logic       watchdog_run;
        logic       external_reset_pin;
        logic       port_e_bit3_input;
        logic       lowpower_t1_osc;
        logic [7:0] analog_pin_control;
        logic       capcmp2_route;
        logic       debug_pins_dedicated;
        logic       extended_isa_on;
        logic       debug_port_on;
        logic       low_voltage_prog_on;
        logic       stack_fault_reset_on;
        logic [3:0] code_lock_block;
        logic       code_lock_eeprom;
        logic       code_lock_boot;
        logic [3:0] write_lock_block;
    } cfgfd_out_type;

    typedef struct packed {
        logic [7:0] pwr_bor;
        logic [7:0] wdog;
        logic [7:0] pin_tmr;
        logic [7:0] dbg_core;
        logic [7:0] blk_cp;
        logic [7:0] boot_cp;
        logic [7:0] blk_wp;
        logic [7:0] rdata;
        cfgfd_out_type dec;
    } cfgfd_state_type;
endpackage

// File: test/cfgfd_bench.sv
module cfgfd_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // design ports
    // ------------------------------------------------------------
    logic                     clock_i;
    logic                     rstn_i;
    logic [21:0]              tbl_addr_i;
    logic                     tbl_rd_i;
    logic                     tbl_wr_i;
    logic [7:0]               tbl_wdata_i;
    logic                     prog_mode_i;
    logic [7:0]               tbl_rdata_o;
    logic                     soft_brownout_on_i;
    logic                     watchdog_soft_on_i;
    logic                     sleep_i;
    cfgfd_pkg::cfgfd_out_type cfg_o;
    int                       fails;
    int                       num_checks;
    logic [7:0]               got;
    logic [21:0]              adr [7];
    logic [7:0]               dflt [7];
    logic [21:0]              wa [9];
    logic [7:0]               wd [9];
    logic [7:0]               we [9];

    cfgfd_decode dut (.clock_i(clock_i), .rstn_i(rstn_i), .tbl_addr_i(tbl_addr_i),
        .tbl_rd_i(tbl_rd_i), .tbl_wr_i(tbl_wr_i), .tbl_wdata_i(tbl_wdata_i),
        .prog_mode_i(prog_mode_i), .tbl_rdata_o(tbl_rdata_o),
        .soft_brownout_on_i(soft_brownout_on_i), .watchdog_soft_on_i(watchdog_soft_on_i),
        .sleep_i(sleep_i), .cfg_o(cfg_o));

    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read request held over two edges so registered or direct data has settled
    task automatic rd_byte(input logic [21:0] a, output logic [7:0] d);
        @(posedge clock_i);
        #1 tbl_addr_i = a;
        tbl_rd_i = 1'b1;
        @(posedge clock_i);
        @(posedge clock_i);
        #1 d = tbl_rdata_o;
        tbl_rd_i = 1'b0;
    endtask

    task automatic wr_byte(input logic [21:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1 tbl_addr_i = a;
        tbl_wdata_i = d;
        tbl_wr_i = 1'b1;
        @(posedge clock_i);
        #1 tbl_wr_i = 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200us;
        fails++;
        summarize();
    end

    initial
    begin
        adr = '{cfgfd_pkg::ADDR_PWR_BOR, cfgfd_pkg::ADDR_WDOG, cfgfd_pkg::ADDR_PIN_TMR,
                cfgfd_pkg::ADDR_DBG_CORE, cfgfd_pkg::ADDR_BLK_CP, cfgfd_pkg::ADDR_BOOT_CP,
                cfgfd_pkg::ADDR_BLK_WP};
        dflt = '{8'h1f, 8'h1f, 8'h83, 8'h85, 8'h0f, 8'hc0, 8'h0f};
        wa = '{adr[0], adr[0], adr[1], adr[2], adr[3], adr[4], adr[4], adr[6], adr[5]};
        wd = '{8'h00, 8'hff, 8'he0, 8'h78, 8'h1a, 8'hfa, 8'hff, 8'hfd, 8'h3f};
        we = '{8'h00, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h0a, 8'h0d, 8'h00};
        fails = 0;
        num_checks = 0;
        {rstn_i, tbl_rd_i, tbl_wr_i, prog_mode_i} = 4'h0;
        {soft_brownout_on_i, watchdog_soft_on_i, sleep_i} = 3'h0;
        tbl_addr_i = 22'h000000;
        tbl_wdata_i = 8'h00;
        repeat (8) @(posedge clock_i);
        #1 rstn_i = 1'b1;
        prog_mode_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1;
        // unprogrammed decode
        check(16'(cfg_o.powerup_delay_timer), 16'h0000);
        check(16'({cfg_o.code_lock_block, cfg_o.write_lock_block}), 16'h0000);
        check(16'({cfg_o.code_lock_eeprom, cfg_o.code_lock_boot}), 16'h0000);
        check(16'(cfg_o.usb_regulator_on), 16'h0000);
        check(16'(cfg_o.brownout_mode), 16'(cfgfd_pkg::BOR_HW));
        check(16'(cfg_o.brownout_level_sel), 16'h0003);
        check(cfg_o.watchdog_ratio, 16'h8000);
        check(16'({cfg_o.external_reset_pin, cfg_o.port_e_bit3_input}), 16'h0002);
        check(16'(cfg_o.lowpower_t1_osc), 16'h0000);
        check(16'(cfg_o.analog_pin_control), 16'(cfgfd_pkg::ANALOG_ON_RESET));
        check(16'(cfg_o.capcmp2_route), 16'h0001);
        check(16'(cfg_o.debug_pins_dedicated), 16'h0000);
        check(16'({cfg_o.extended_isa_on, cfg_o.debug_port_on}), 16'h0000);
        check(16'({cfg_o.low_voltage_prog_on, cfg_o.stack_fault_reset_on}), 16'h0003);
        // hardware-only brownout and watchdog stay active with soft controls raised and sleep low
        #1 {soft_brownout_on_i, watchdog_soft_on_i, sleep_i} = 3'h6;
        repeat (2) @(posedge clock_i);
        #1;
        check(16'({cfg_o.brownout_active, cfg_o.watchdog_run}), 16'h0003);
        for (int i = 0; i < 7; i++)
        begin
            rd_byte(adr[i], got);
            check(16'(got), 16'(dflt[i]));
        end
        for (int i = 0; i < 9; i++)
        begin
            wr_byte(wa[i], wd[i]);
            rd_byte(wa[i], got);
            check(16'(got), 16'(we[i]));
        end
        // decoded values stay latched until the next reset
        check(16'(cfg_o.usb_regulator_on), 16'h0000);
        check(16'(cfg_o.code_lock_block), 16'h0000);
        summarize();
    end
endmodule
